// *** logic/decode_pkg.sv ***
// Constants, encodings and cycle costs for the opcode decoder and address-timing block.
// Assumes a single processor clock; values here serve the decoder logic, the assertions and the bench.
// What this block does
// - Form 11 makes selector a register number
// - Form picks displacement: none, byte sign-extended, word
// - Selectors 000-011 add base/frame and index pairs
// - Selector 110 frame plus disp; 111 base plus disp
// - Displacement bytes follow second byte, before immediates
// - Offset formation costs four cycles, already counted
// - Override prefix 001ss110 picks the operand segment
// - Register field picks word or byte register
// - Signed multiply costs 25-28/34-37, memory 31-34/40-43
// - Unsigned divide costs 29, 38, 35 cycles
// - Signed divide costs 44-52 or 53-61 cycles
// - Ascii adjusts need 0a second byte; 19/15
// - Repeated string cost is overhead plus per element
// - Conditional jump costs 4 not taken, 13 taken
// - Loop forms cost 6 not taken, 16 taken
// - Jump-if-count-zero costs 5 or 15 cycles
// - Procedure entry costs 15, 25, 22+16(n-1)
// - Overflow trap costs 48 taken, 4 not
// - Trap return costs 28 cycles
// - Range check 62 with modrm costs 33-35
// - Coprocessor pass costs 6, forwards sub-op bits
// - Lock prefix costs 2, locks next instruction
// - Frame pointer operands default to stack segment
// - Unrepeated move/store string destination always extra segment, no override
// - Form 00 selector 110 gives direct 16-bit offset
package decode_pkg;
    // Addressing forms
    localparam logic [1:0] FORM_NODISP = 2'h0;
    localparam logic [1:0] FORM_DISP8  = 2'h1;
    localparam logic [1:0] FORM_DISP16 = 2'h2;
    localparam logic [1:0] FORM_REG    = 2'h3;
    // Selector codes with special meaning
    localparam logic [2:0] SEL_FRAME   = 3'h6;
    // Segment codes
    localparam logic [1:0] SEG_EXTRA = 2'h0;
    localparam logic [1:0] SEG_CODE  = 2'h1;
    localparam logic [1:0] SEG_STACK = 2'h2;
    localparam logic [1:0] SEG_DATA  = 2'h3;
    // Opcodes recognised by this block
    localparam logic [7:0] OP_GRP3_HI    = 8'hf6;  // 1111011w, w masked
    localparam logic [7:0] OP_AMUL_ADJ   = 8'hd4;
    localparam logic [7:0] OP_ADIV_ADJ   = 8'hd5;
    localparam logic [7:0] ADJ_SECOND    = 8'h0a;
    localparam logic [7:0] OP_LOOPNZ     = 8'he0;
    localparam logic [7:0] OP_LOOPZ      = 8'he1;
    localparam logic [7:0] OP_LOOP       = 8'he2;
    localparam logic [7:0] OP_JCZ        = 8'he3;
    localparam logic [7:0] OP_ENTER      = 8'hc8;
    localparam logic [7:0] OP_OVF_TRAP   = 8'hce;
    localparam logic [7:0] OP_TRAP_RET   = 8'hcf;
    localparam logic [7:0] OP_RANGE      = 8'h62;
    localparam logic [7:0] OP_LOCK       = 8'hf0;
    localparam logic [7:0] OP_REPEAT     = 8'hf2;  // 1111001z, z masked
    localparam logic [7:0] OP_SHIFT1     = 8'hd0;  // 1101000w
    localparam logic [7:0] OP_SHIFTCL    = 8'hd2;  // 1101001w
    localparam logic [7:0] OP_SHIFTIMM   = 8'hc0;  // 1100000w
    // Group-3 sub-operations
    localparam logic [2:0] G3_SIGNED_MULTIPLY = 3'h5;
    localparam logic [2:0] G3_DIV  = 3'h6;
    localparam logic [2:0] G3_SIGNED_QUOTIENT = 3'h7;
    // Timing constants, in clock cycles
    localparam int EA_CYCLES      = 4;
    localparam int SIGNED_MULTIPLY_RB_MIN    = 25;
    localparam int SIGNED_MULTIPLY_RB_MAX    = 28;
    localparam int SIGNED_MULTIPLY_RW_MIN    = 34;
    localparam int SIGNED_MULTIPLY_RW_MAX    = 37;
    localparam int SIGNED_MULTIPLY_MB_MIN    = 31;
    localparam int SIGNED_MULTIPLY_MB_MAX    = 34;
    localparam int SIGNED_MULTIPLY_MW_MIN    = 40;
    localparam int SIGNED_MULTIPLY_MW_MAX    = 43;
    localparam int DIV_RB         = 29;
    localparam int DIV_RW         = 38;
    localparam int DIV_MB         = 35;
    localparam int SIGNED_QUOTIENT_RB_MIN    = 44;
    localparam int SIGNED_QUOTIENT_RB_MAX    = 52;
    localparam int SIGNED_QUOTIENT_RW_MIN    = 53;
    localparam int SIGNED_QUOTIENT_RW_MAX    = 61;
    localparam int AMUL_ADJ_CYC   = 19;
    localparam int ADIV_ADJ_CYC   = 15;
    localparam int MOVS_FIX       = 8;
    localparam int MOVS_PER       = 8;
    localparam int CMPS_FIX       = 5;
    localparam int CMPS_PER       = 22;
    localparam int SCAS_FIX       = 5;
    localparam int SCAS_PER       = 15;
    localparam int LODS_FIX       = 6;
    localparam int LODS_PER       = 11;
    localparam int STOS_FIX       = 6;
    localparam int STOS_PER       = 9;
    localparam int JCC_NOT        = 4;
    localparam int JCC_TAKEN      = 13;
    localparam int LOOP_NOT       = 6;
    localparam int LOOP_TAKEN     = 16;
    localparam int JCZ_NOT        = 5;
    localparam int JCZ_TAKEN      = 15;
    localparam int ENTER_L0       = 15;
    localparam int ENTER_L1       = 25;
    localparam int ENTER_BASE     = 22;
    localparam int ENTER_PER      = 16;
    localparam int TRAP_TAKEN     = 48;
    localparam int TRAP_NOT       = 4;
    localparam int TRAP_RET_CYC   = 28;
    localparam int RANGE_MIN      = 33;
    localparam int RANGE_MAX      = 35;
    localparam int COPROC_CYC     = 6;
    localparam int LOCK_CYC       = 2;
    // Register identifiers for the register field
    typedef enum logic [3:0] {
        R_AX, R_CX, R_DX, R_BX, R_SP, R_BP, R_SI, R_DI,
        R_AL, R_CL, R_DL, R_BL, R_AH, R_CH, R_DH, R_BH
    } reg_id_t;
    // Shift/rotate kinds
    typedef enum logic [2:0] {
        SH_ROL, SH_ROR, SH_RCL, SH_RCR, SH_SHL, SH_SHR, SH_BAD, SH_SAR
    } shift_kind_t;
endpackage

// *** logic/opcode_decode_and_ea_timing.sv ***
// Instruction decoder: addressing form, offset, segment, register and cycle cost.
// Assumes the prefetch queue presents up to six instruction bytes at once with a valid
// strobe, and the datapath supplies register values and outcome hints in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module opcode_decode_and_ea_timing
    import decode_pkg::*;
#(
    parameter int CYC_W = 12            // Width of the cycle-count result
) (
    input  wire logic              sys_clk,          // Processor clock
    input  wire logic              reset_n,          // Synchronous reset, active low
    input  wire logic              instr_valid,      // Instruction bytes valid
    input  wire logic [47:0]       instr_bytes,      // Byte 0 in bits 7:0
    input  wire logic [15:0]       base_reg,         // Base register value
    input  wire logic [15:0]       frame_pointer,    // Frame pointer value
    input  wire logic [15:0]       src_index,        // Source index value
    input  wire logic [15:0]       dest_index,       // Destination index value
    input  wire logic [15:0]       count_reg,        // Count register value
    input  wire logic              branch_taken,     // Condition outcome from flags
    input  wire logic              overflow_flag,    // Overflow flag for the trap
    input  wire logic [1:0]        data_extra,       // Data-dependent extra cycles
    input  wire logic [4:0]        nest_level,       // Procedure entry nesting level
    output logic                   dec_valid,        // Decoded result valid
    output logic                   is_prefix,        // Byte 0 was an override or lock prefix
    output logic                   bus_lock,         // Exclusive bus ownership
    output logic [1:0]             seg_sel,          // Segment for memory operand
    output logic                   seg_pending,      // Override waits for next op
    output logic                   mem_operand,      // Operand is in memory
    output logic [15:0]            effective_offset, // Operand offset
    output logic [2:0]             disp_len,         // Displacement byte count
    output reg_id_t                reg_field_id,     // Register from reg field
    output reg_id_t                rm_reg_id,        // Register from selector
    output shift_kind_t            shift_kind,       // Shift/rotate sub-operation
    output logic [4:0]             coproc_opcode,    // Forwarded sub_op/low fields
    output logic                   coproc_valid,     // Coprocessor opcode valid
    output logic                   illegal,          // Bad second byte
    output logic [CYC_W-1:0]       cycle_count       // Execution cycles
);

    // Byte fields
    logic [7:0]  op;               // First byte
    logic [7:0]  modrm;            // Second byte
    logic [1:0]  form;             // Addressing form
    logic [2:0]  regf;             // Register / sub-operation field
    logic [2:0]  sel;              // Operand selector
    logic        wide;             // Width bit
    logic [15:0] disp;             // Selected displacement
    logic [15:0] next_offset;      // Offset being formed
    logic [1:0]  next_seg;         // Default segment
    logic [CYC_W-1:0] next_cyc;    // Cost being formed
    logic [1:0]  ovr_seg;          // Held override code
    logic        ovr_act;          // Override held for the next instruction
    logic        lock_hold;        // Lock prefix seen

    assign op    = instr_bytes[7:0];
    assign modrm = instr_bytes[15:8];
    assign form  = modrm[7:6];
    assign regf  = modrm[5:3];
    assign sel   = modrm[2:0];
    assign wide  = op[0];

    // Register identifier from a 3-bit code and the width bit
    function automatic reg_id_t reg_lookup(input logic [2:0] code, input logic w);
        reg_lookup = reg_id_t'({~w, code});
    endfunction

    // Prefix recognition
    function automatic logic is_override(input logic [7:0] b);
        is_override = (b[7:5] == 3'h1) && (b[2:0] == 3'h6);
    endfunction

    // Displacement selection; bytes sit right after the second byte
    always_comb begin
        case (form)
            FORM_DISP8:  disp = {{8{instr_bytes[23]}}, instr_bytes[23:16]};
            FORM_DISP16: disp = instr_bytes[31:16];
            default:     disp = 16'h0000;
        endcase
    end

    // Offset formation and default segment
    always_comb begin
        next_seg = SEG_DATA;
        case (sel)
            3'h0: next_offset = base_reg + src_index + disp;
            3'h1: next_offset = base_reg + dest_index + disp;
            3'h2: begin
                next_offset = frame_pointer + src_index + disp;
                next_seg    = SEG_STACK;
            end
            3'h3: begin
                next_offset = frame_pointer + dest_index + disp;
                next_seg    = SEG_STACK;
            end
            3'h4: next_offset = src_index + disp;
            3'h5: next_offset = dest_index + disp;
            3'h6: begin
                if (form == FORM_NODISP) begin
                    next_offset = instr_bytes[31:16];
                end else begin
                    next_offset = frame_pointer + disp;
                    next_seg    = SEG_STACK;
                end
            end
            default: next_offset = base_reg + disp;
        endcase
    end

    // Cycle cost table
    always_comb begin
        next_cyc = CYC_W'(2);
        if ((op & 8'hfe) == OP_GRP3_HI && regf == G3_SIGNED_MULTIPLY) begin
            if (form == FORM_REG)
                next_cyc = CYC_W'((wide ? SIGNED_MULTIPLY_RW_MIN : SIGNED_MULTIPLY_RB_MIN) + data_extra);
            else
                next_cyc = CYC_W'((wide ? SIGNED_MULTIPLY_MW_MIN : SIGNED_MULTIPLY_MB_MIN) + data_extra);
        end else if ((op & 8'hfe) == OP_GRP3_HI && regf == G3_DIV) begin
            if (form == FORM_REG)
                next_cyc = CYC_W'(wide ? DIV_RW : DIV_RB);
            else
                next_cyc = CYC_W'(DIV_MB);
        end else if ((op & 8'hfe) == OP_GRP3_HI && regf == G3_SIGNED_QUOTIENT) begin
            // Range reach comes from data_extra scaled to the 8-cycle spread;
            // the step count is capped at two so the cost never leaves the range
            next_cyc = CYC_W'((wide ? SIGNED_QUOTIENT_RW_MIN : SIGNED_QUOTIENT_RB_MIN)
                              + 32'(data_extra > 2'h2 ? 2'h2 : data_extra)
                              * 4);
        end else if (op == OP_AMUL_ADJ) begin
            next_cyc = CYC_W'(AMUL_ADJ_CYC);
        end else if (op == OP_ADIV_ADJ) begin
            next_cyc = CYC_W'(ADIV_ADJ_CYC);
        end else if ((op & 8'hfe) == OP_REPEAT) begin
            case (instr_bytes[15:9])
                7'h52:   next_cyc = CYC_W'(MOVS_FIX + MOVS_PER * 32'(count_reg));
                7'h53:   next_cyc = CYC_W'(CMPS_FIX + CMPS_PER * 32'(count_reg));
                7'h57:   next_cyc = CYC_W'(SCAS_FIX + SCAS_PER * 32'(count_reg));
                7'h56:   next_cyc = CYC_W'(LODS_FIX + LODS_PER * 32'(count_reg));
                7'h55:   next_cyc = CYC_W'(STOS_FIX + STOS_PER * 32'(count_reg));
                default: next_cyc = CYC_W'(2);
            endcase
        end else if (op[7:4] == 4'h7) begin
            next_cyc = CYC_W'(branch_taken ? JCC_TAKEN : JCC_NOT);
        end else if (op == OP_LOOP || op == OP_LOOPZ || op == OP_LOOPNZ) begin
            next_cyc = CYC_W'(branch_taken ? LOOP_TAKEN : LOOP_NOT);
        end else if (op == OP_JCZ) begin
            next_cyc = CYC_W'((count_reg == 16'h0000) ? JCZ_TAKEN : JCZ_NOT);
        end else if (op == OP_ENTER) begin
            if (nest_level == 5'h00)
                next_cyc = CYC_W'(ENTER_L0);
            else if (nest_level == 5'h01)
                next_cyc = CYC_W'(ENTER_L1);
            else
                next_cyc = CYC_W'(ENTER_BASE + ENTER_PER * (32'(nest_level) - 1));
        end else if (op == OP_OVF_TRAP) begin
            next_cyc = CYC_W'(overflow_flag ? TRAP_TAKEN : TRAP_NOT);
        end else if (op == OP_TRAP_RET) begin
            next_cyc = CYC_W'(TRAP_RET_CYC);
        end else if (op == OP_RANGE) begin
            next_cyc = CYC_W'(RANGE_MIN + 32'(data_extra > 2'h2 ? 2'h2 : data_extra));
        end else if (op[7:3] == 5'h13) begin
            next_cyc = CYC_W'(COPROC_CYC);
        end else if (op == OP_LOCK || is_override(op)) begin
            next_cyc = CYC_W'(LOCK_CYC);
        end
        // Offset formation time is inside the table values: nothing added
    end

    // Prefix state: override and lock apply to the next instruction only
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ovr_act   <= 1'b0;
            ovr_seg   <= SEG_DATA;
            lock_hold <= 1'b0;
        end else if (instr_valid) begin
            if (is_override(op)) begin
                ovr_act <= 1'b1;
                ovr_seg <= op[4:3];
            end else if (op != OP_LOCK && (op & 8'hfe) != OP_REPEAT) begin
                ovr_act <= 1'b0;
            end
            lock_hold <= (op == OP_LOCK);
        end
    end

    // Decoded outputs
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            dec_valid        <= 1'b0;
            is_prefix        <= 1'b0;
            bus_lock         <= 1'b0;
            seg_sel          <= SEG_DATA;
            seg_pending      <= 1'b0;
            mem_operand      <= 1'b0;
            effective_offset <= 16'h0000;
            disp_len         <= 3'h0;
            reg_field_id     <= R_AX;
            rm_reg_id        <= R_AX;
            shift_kind       <= SH_ROL;
            coproc_opcode    <= 5'h00;
            coproc_valid     <= 1'b0;
            illegal          <= 1'b0;
            cycle_count      <= '0;
        end else begin
            dec_valid    <= instr_valid;
            is_prefix    <= instr_valid && (is_override(op) || op == OP_LOCK);
            seg_pending  <= ovr_act;
            coproc_valid <= instr_valid && op[7:3] == 5'h13;
            if (instr_valid) begin
                bus_lock     <= lock_hold || op == OP_LOCK;
                mem_operand  <= (form != FORM_REG);
                reg_field_id <= reg_lookup(regf, wide);
                rm_reg_id    <= reg_lookup(sel, wide);
                shift_kind   <= shift_kind_t'(regf);
                coproc_opcode <= {op[2:0], regf[1:0]};
                illegal      <= (op == OP_AMUL_ADJ || op == OP_ADIV_ADJ)
                                && modrm != ADJ_SECOND;
                cycle_count  <= next_cyc;
                if (form == FORM_REG) begin
                    effective_offset <= 16'h0000;
                    disp_len         <= 3'h0;
                end else begin
                    effective_offset <= next_offset;
                    disp_len <= (form == FORM_DISP16 ||
                                 (form == FORM_NODISP && sel == SEL_FRAME)) ? 3'h2 :
                                (form == FORM_DISP8) ? 3'h1 : 3'h0;
                end
                // Move/store string destination is fixed to the extra segment
                if ((op & 8'hfe) == 8'ha4 || (op & 8'hfe) == 8'haa)
                    seg_sel <= SEG_EXTRA;
                else if (ovr_act)
                    seg_sel <= ovr_seg;
                else
                    seg_sel <= next_seg;
            end
        end
    end

    // Assertions
    a_reg_form_offset: assert property (@(posedge sys_clk) disable iff (!reset_n)
        instr_valid && form == FORM_REG |=> effective_offset == 16'h0000 && !mem_operand)
        else $error("register form produced an offset");
    a_disp8_sign: assert property (@(posedge sys_clk) disable iff (!reset_n)
        instr_valid && form == FORM_DISP8 && sel == 3'h7 |=>
        effective_offset == $past(base_reg) + {{8{$past(instr_bytes[23])}},
        $past(instr_bytes[23:16])})
        else $error("byte displacement not sign extended");
    a_pair_sum: assert property (@(posedge sys_clk) disable iff (!reset_n)
        instr_valid && form == FORM_NODISP && sel == 3'h3 |=>
        effective_offset == $past(frame_pointer) + $past(dest_index))
        else $error("frame plus dest offset wrong");
    a_direct_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
        instr_valid && form == FORM_NODISP && sel == SEL_FRAME && !ovr_act |=>
        effective_offset == $past(instr_bytes[31:16]) && seg_sel == SEG_DATA)
        else $error("direct offset wrong");
    a_frame_stack: assert property (@(posedge sys_clk) disable iff (!reset_n)
        instr_valid && form == FORM_DISP8 && sel == SEL_FRAME && !ovr_act
        && op[7:4] != 4'ha |=> seg_sel == SEG_STACK)
        else $error("frame operand not on stack");
    a_jcc_cost: assert property (@(posedge sys_clk) disable iff (!reset_n)
        instr_valid && op == 8'h74 |=>
        cycle_count == CYC_W'($past(branch_taken) ? 13 : 4))
        else $error("conditional jump cost wrong");
    a_jcz_cost: assert property (@(posedge sys_clk) disable iff (!reset_n)
        instr_valid && op == OP_JCZ && count_reg == 16'h0000 |=> cycle_count == CYC_W'(15))
        else $error("count zero jump cost wrong");
    a_div_cost: assert property (@(posedge sys_clk) disable iff (!reset_n)
        instr_valid && op == 8'hf7 && regf == G3_DIV && form == FORM_REG |=>
        cycle_count == CYC_W'(38))
        else $error("word divide cost wrong");
    a_signed_quotient_range: assert property (@(posedge sys_clk) disable iff (!reset_n)
        instr_valid && op == 8'hf6 && regf == G3_SIGNED_QUOTIENT |=>
        cycle_count >= CYC_W'(44) && cycle_count <= CYC_W'(52))
        else $error("signed byte divide out of range");
    a_lock_next: assert property (@(posedge sys_clk) disable iff (!reset_n)
        instr_valid && op == OP_LOCK ##1 instr_valid |=> bus_lock)
        else $error("lock did not cover next instruction");
    a_override_seg: assert property (@(posedge sys_clk) disable iff (!reset_n)
        instr_valid && op == 8'h26 ##1 instr_valid && op[7:4] == 4'h8 |=>
        seg_sel == SEG_EXTRA)
        else $error("override segment not applied");

    // Prefix bookkeeping: flag and held override
    a_prefix_flag: assert property (@(posedge sys_clk) disable iff (!reset_n)
        instr_valid && is_override(op) |=> is_prefix && ovr_act)
        else $error("override prefix not held");

    // Fixed costs of single-outcome instructions
    a_coproc_cost: assert property (@(posedge sys_clk) disable iff (!reset_n)
        instr_valid && op[7:3] == 5'h13 |=>
        cycle_count == CYC_W'(6) && coproc_valid)
        else $error("coprocessor pass wrong");
    a_trap_ret: assert property (@(posedge sys_clk) disable iff (!reset_n)
        instr_valid && op == OP_TRAP_RET |=> cycle_count == CYC_W'(28))
        else $error("trap return cost wrong");

    // Loop cost follows the outcome
    a_loop_cost: assert property (@(posedge sys_clk) disable iff (!reset_n)
        instr_valid && op == OP_LOOP |=>
        cycle_count == CYC_W'($past(branch_taken) ? 16 : 6))
        else $error("loop cost wrong");

    // Adjust opcodes need the fixed second byte
    a_adjust_bad: assert property (@(posedge sys_clk) disable iff (!reset_n)
        instr_valid && op == OP_AMUL_ADJ && modrm != 8'h0a |=> illegal)
        else $error("bad adjust byte not flagged");

    // Word displacement occupies two bytes
    a_disp_word: assert property (@(posedge sys_clk) disable iff (!reset_n)
        instr_valid && form == FORM_DISP16 |=> disp_len == 3'h2)
        else $error("word displacement length wrong");

    // String destination ignores any override
    a_string_extra: assert property (@(posedge sys_clk) disable iff (!reset_n)
        instr_valid && op == 8'ha4 |=> seg_sel == SEG_EXTRA)
        else $error("string destination segment wrong");

    // Cover properties
    c_override_then_op: cover property (@(posedge sys_clk) disable iff (!reset_n)
        instr_valid && is_override(op) ##1 instr_valid && !is_override(op));
    c_repeat_move: cover property (@(posedge sys_clk) disable iff (!reset_n)
        instr_valid && op == OP_REPEAT && modrm == 8'ha5);
    c_enter_deep: cover property (@(posedge sys_clk) disable iff (!reset_n)
        instr_valid && op == OP_ENTER && nest_level > 5'h01);
    c_trap_taken: cover property (@(posedge sys_clk) disable iff (!reset_n)
        instr_valid && op == OP_OVF_TRAP && overflow_flag);
    c_bad_adjust: cover property (@(posedge sys_clk) disable iff (!reset_n)
        instr_valid && op == OP_AMUL_ADJ && modrm != ADJ_SECOND);
endmodule
`default_nettype wire

// *** testbench/byte_feeder.sv ***
// Stand-in for the prefetch queue: presents one instruction's bytes for one cycle.
// Assumes a single caller process and outputs sampled on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module byte_feeder (
    input  wire logic        sys_clk,     // Processor clock
    output var  logic        instr_valid = 1'b0, // Bytes valid this cycle
    output var  logic [47:0] instr_bytes = 48'h0 // Byte 0 in bits 7:0
);
    // Drive off the sampling edge; when idle, show the inverse so stale bytes never pass
    task automatic send(input logic [47:0] b);
        @(negedge sys_clk);
        instr_valid = 1'b1;
        instr_bytes = b;
        @(negedge sys_clk);
        instr_valid = 1'b0;
        instr_bytes = ~b;
    endtask
endmodule
`default_nettype wire

// *** testbench/opcode_decode_and_ea_timing_bench.sv ***
// Self-checking bench: offsets, segments, register fields and cycle costs of the decoder.
// Assumes the byte feeder model and results settled one rising edge after taking.
`timescale 1ns/1ps
`default_nettype none
module opcode_decode_and_ea_timing_bench
    import decode_pkg::*;
;
    logic        sys_clk = 1'b0, reset_n = 1'b0, branch_taken = 1'b0, overflow_flag = 1'b0;
    logic        instr_valid, dec_valid, is_prefix, bus_lock, seg_pending, mem_operand;
    logic        coproc_valid, illegal;
    logic [47:0] instr_bytes;
    logic [15:0] base_reg = 16'h1000, frame_pointer = 16'h4000, src_index = 16'h0200;
    logic [15:0] dest_index = 16'h0030, count_reg = 16'h0, effective_offset;
    logic [1:0]  data_extra = 2'h0, seg_sel;
    logic [4:0]  nest_level = 5'h0, coproc_opcode;
    logic [2:0]  disp_len;
    logic [11:0] cycle_count;
    reg_id_t     reg_field_id, rm_reg_id;
    shift_kind_t shift_kind;
    int          fail_count = 0, n_compared = 0;
    byte_feeder u_byte_feeder (.sys_clk, .instr_valid, .instr_bytes);
    opcode_decode_and_ea_timing #(.CYC_W(12)) u_opcode_decode_and_ea_timing (
        .sys_clk, .reset_n, .instr_valid, .instr_bytes, .base_reg, .frame_pointer, .src_index,
        .dest_index, .count_reg, .branch_taken, .overflow_flag, .data_extra, .nest_level,
        .dec_valid, .is_prefix, .bus_lock, .seg_sel, .seg_pending, .mem_operand, .effective_offset,
        .disp_len, .reg_field_id, .rm_reg_id, .shift_kind, .coproc_opcode, .coproc_valid,
        .illegal, .cycle_count);
    initial forever #5 sys_clk = ~sys_clk;
    // Compare and count; a mismatch reports at once
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One instruction through the feeder, then confirm the result strobe
    task automatic go(input logic [47:0] b);
        u_byte_feeder.send(b);
        chk({15'h0, dec_valid}, 16'h1);
    endtask
    // Cycle cost of a two-byte instruction under a given outcome and count
    task automatic tc(input logic [15:0] b, input logic tk, input logic [15:0] n, input int exp);
        branch_taken = tk;
        overflow_flag = tk;
        count_reg = n;
        nest_level = n[4:0];
        go({32'h0, b});
        chk({4'h0, cycle_count}, 16'(exp));
    endtask
    // Every selector with a word displacement, then direct, byte and register forms
    task automatic t_offsets();
        logic [15:0] e [8];
        e = '{16'h1200, 16'h1030, 16'h4200, 16'h4030, 16'h0200, 16'h0030, 16'h4000, 16'h1000};
        for (int i = 0; i < 8; i++) begin
            go({16'h0, 16'h1234, 8'h80 | 8'(i), 8'h8b});
            chk(effective_offset, e[i] + 16'h1234);
            chk({13'h0, disp_len}, 16'h2);
        end
        go({16'h0, 16'h5678, 8'h06, 8'h8b});
        chk(effective_offset, 16'h5678);
        go({24'h0, 8'hf0, 8'h46, 8'h8b});
        chk({effective_offset[15:2], seg_sel}, {14'h0ffc, SEG_STACK});
        go({32'h0, 8'hec, 8'h8b});
        chk({7'h0, mem_operand, reg_field_id, rm_reg_id}, {8'h0, R_BP, R_SP});
        go({32'h0, 8'he1, 8'h8a});
        chk({7'h0, mem_operand, reg_field_id, rm_reg_id}, {8'h0, R_AH, R_CL});
    endtask
    // Each override code steers the next frame-pointer operand; lock covers the next one
    task automatic t_segments();
        for (int s = 0; s < 4; s++) begin
            go({40'h0, 8'h26 | 8'(s << 3)});
            chk({15'h0, is_prefix}, 16'h1);
            go({24'h0, 8'h10, 8'h46, 8'h8b});
            chk({14'h0, seg_sel}, 16'(s));
            chk({14'h0, is_prefix, seg_pending}, 16'h1);
        end
        go({40'h0, 8'hf0});
        go({32'h0, 8'hc1, 8'h8b});
        chk({15'h0, bus_lock}, 16'h1);
    endtask
    // Cycle costs for both outcomes of branches, traps, entry levels and long operations
    task automatic t_timing();
        tc(16'h0574, 1'b0, 16'h1, JCC_NOT);
        tc(16'h0574, 1'b1, 16'h0, JCC_TAKEN);
        tc(16'h05e2, 1'b0, 16'h1, LOOP_NOT);
        tc(16'h05e2, 1'b1, 16'h2, LOOP_TAKEN);
        tc(16'h05e3, 1'b0, 16'h1, JCZ_NOT);
        tc(16'h05e3, 1'b1, 16'h0, JCZ_TAKEN);
        tc(16'h00c8, 1'b0, 16'h3, ENTER_BASE + 2 * ENTER_PER);
        tc(16'h00c8, 1'b0, 16'h1, ENTER_L1);
        tc(16'h00ce, 1'b1, 16'h0, TRAP_TAKEN);
        tc(16'h00ce, 1'b0, 16'h0, TRAP_NOT);
        tc(16'h00cf, 1'b0, 16'h0, TRAP_RET_CYC);
        tc(16'h0ad4, 1'b0, 16'h0, AMUL_ADJ_CYC);
        tc(16'h0ad5, 1'b0, 16'h0, ADIV_ADJ_CYC);
        tc(16'h2cf6, 1'b0, 16'h0, SIGNED_MULTIPLY_MB_MIN);
        tc(16'hf1f7, 1'b0, 16'h0, DIV_RW);
        tc(16'hf9f6, 1'b0, 16'h0, SIGNED_QUOTIENT_RB_MIN);
        tc(16'ha4f2, 1'b0, 16'h3, MOVS_FIX + 3 * MOVS_PER);
        tc(16'h0462, 1'b0, 16'h0, RANGE_MIN);
        tc(16'h189d, 1'b0, 16'h0, COPROC_CYC);
        tc(16'h00f0, 1'b0, 16'h0, LOCK_CYC);
    endtask
    // Bad adjust byte, forwarded coprocessor fields and every shift kind
    task automatic t_misc();
        go({32'h0, 8'h0b, 8'hd4});
        chk({15'h0, illegal}, 16'h1);
        go({32'h0, 8'h18, 8'h9d});
        chk({10'h0, coproc_valid, coproc_opcode}, 16'h37);
        for (int k = 0; k < 8; k++) begin
            go({32'h0, 8'hc0 | 8'(k << 3), 8'hd1});
            chk({13'h0, shift_kind}, 16'(k));
        end
    endtask
    // Verdict and end of run
    task automatic complete_run();
        if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Reset for five cycles, then the scenarios
    initial begin
        repeat (5) @(negedge sys_clk);
        reset_n = 1'b1;
        t_offsets();
        t_segments();
        t_timing();
        t_misc();
        complete_run();
    end
    // Hang guard, well beyond the roughly 110 cycles the scenarios need
    initial begin
        #50000;
        fail_count++;
        complete_run();
    end
endmodule
`default_nettype wire
